// ### hdl/tic_consts.svh
// Offsets, bit positions, reset values and sizes of the timer/interrupt control bank
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH
`define TIC_ADDR_W 8
`define TIC_OFF_CTRL 8'h88
`define TIC_OFF_IRQ_STAT 8'h8C
`define TIC_OFF_IRQ_MASK 8'h90
`define TIC_OFF_POLARITY 8'h94
`define TIC_BIT_T1OVF 7
`define TIC_BIT_T1RUN 6
`define TIC_BIT_T0OVF 5
`define TIC_BIT_T0RUN 4
`define TIC_BIT_E1FLAG 3
`define TIC_BIT_E1TYPE 2
`define TIC_BIT_E0FLAG 1
`define TIC_BIT_E0TYPE 0
`define TIC_CTRL_RST 8'h00
`define TIC_MASK_RST 8'h00
`define TIC_POL_RST 2'h0
`define TIC_NUM_EVT 4
`endif

// ### hdl/tic_pkg.sv
// Types shared by the timer/interrupt control bank
package tic_pkg;
  typedef logic [7:0] tic_byte_t;
  typedef logic [31:0] tic_word_t;
  typedef enum logic [1:0] {
    TIC_IDLE = 2'b00,
    TIC_RESP = 2'b01
  } tic_bus_e;
endpackage

// ### hdl/tic_sync.sv
// Two-flop synchroniser for one external level
`timescale 1ns/1ps
`default_nettype none
module tic_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  // First stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Idle-high reset level, so an active-low pin does not look active
      meta_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tic_ext_det.sv
// Edge or level detector for one external interrupt input with its flag
`timescale 1ns/1ps
`default_nettype none
module tic_ext_det (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pinSync,
  input wire logic activeHigh,
  input wire logic edgeMode,
  input wire logic swClear,
  input wire logic vecClear,
  output logic flag,
  output logic edgeSeen
);
  logic active;
  logic prevActive_r;
  logic latch_r;
  logic latch_nxt;
  // Polarity comes from the separate pin configuration, not the control byte
  assign active = activeHigh ? pinSync : ~pinSync;
  assign edgeSeen = active & ~prevActive_r & edgeMode;
  // Set wins over any clear in the same cycle
  assign latch_nxt = edgeSeen ? 1'b1 : ((swClear | vecClear) ? 1'b0 : latch_r);
  // Level mode follows the pin directly; edge mode shows the latch
  assign flag = edgeMode ? latch_r : active;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prevActive_r <= 1'b0;
      latch_r <= 1'b0;
    end else begin
      prevActive_r <= active;
      latch_r <= edgeMode ? latch_nxt : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tic_control.sv
// Timer run/overflow and external interrupt control byte with Avalon-MM slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tic_consts.svh"
module tic_control (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire tic_pkg::tic_word_t avs_writedata,
  output tic_pkg::tic_word_t avs_readdata,
  output logic avs_waitrequest,
  input wire logic t1Overflow,
  input wire logic t0Overflow,
  input wire logic t1Vector,
  input wire logic t0Vector,
  input wire logic ext1Vector,
  input wire logic ext0Vector,
  input wire logic ext_irq_in_one,
  input wire logic ext_irq_in_zero,
  output logic t1RunEn,
  output logic t0RunEn,
  output logic ext1IrqReq,
  output logic ext0IrqReq,
  output logic irq
);
  import tic_pkg::*;

  tic_bus_e busState_r;
  logic t1Ovf_r;
  logic t0Ovf_r;
  logic t1Run_r;
  logic t0Run_r;
  logic e1Type_r;
  logic e0Type_r;
  logic [1:0] polarity_r;
  logic [3:0] irqStat_r;
  logic [3:0] irqStat_nxt;
  logic [3:0] irqMask_r;
  tic_word_t readData_r;
  logic in1Sync;
  logic in0Sync;
  logic e1Flag;
  logic e0Flag;
  logic e1Edge;
  logic e0Edge;
  logic access;
  logic taken;
  logic wrLow;
  logic hitCtrl;
  logic hitStat;
  logic hitMask;
  logic hitPol;
  logic wrCtrl;
  logic rdStat;
  logic t1SwClr;
  logic t0SwClr;
  logic e1SwClr;
  logic e0SwClr;
  logic [3:0] evtVec;
  tic_byte_t ctrlByte;
  tic_word_t readMux;

  // Pins come from outside the clock domain
  tic_sync syncOne (
    .clock(clock),
    .rst_n(rst_n),
    .din(ext_irq_in_one),
    .dout(in1Sync)
  );
  tic_sync syncZero (
    .clock(clock),
    .rst_n(rst_n),
    .din(ext_irq_in_zero),
    .dout(in0Sync)
  );

  // Detectors with polarity from the separate register
  tic_ext_det detOne (
    .clock(clock),
    .rst_n(rst_n),
    .pinSync(in1Sync),
    .activeHigh(polarity_r[1]),
    .edgeMode(e1Type_r),
    .swClear(e1SwClr),
    .vecClear(ext1Vector),
    .flag(e1Flag),
    .edgeSeen(e1Edge)
  );
  tic_ext_det detZero (
    .clock(clock),
    .rst_n(rst_n),
    .pinSync(in0Sync),
    .activeHigh(polarity_r[0]),
    .edgeMode(e0Type_r),
    .swClear(e0SwClr),
    .vecClear(ext0Vector),
    .flag(e0Flag),
    .edgeSeen(e0Edge)
  );

  // Bus decode; one wait cycle so the answer always comes registered
  assign access = avs_read | avs_write;
  assign taken = access && (busState_r == TIC_RESP);
  assign avs_waitrequest = access && (busState_r != TIC_RESP);
  assign wrLow = taken & avs_write & avs_byteenable[0];
  assign hitCtrl = avs_address == `TIC_OFF_CTRL;
  assign hitStat = avs_address == `TIC_OFF_IRQ_STAT;
  assign hitMask = avs_address == `TIC_OFF_IRQ_MASK;
  assign hitPol = avs_address == `TIC_OFF_POLARITY;
  assign wrCtrl = wrLow & hitCtrl;
  assign rdStat = taken & avs_read & hitStat;

  // Software clears only by writing 0 to a flag bit
  assign t1SwClr = wrCtrl & ~avs_writedata[`TIC_BIT_T1OVF];
  assign t0SwClr = wrCtrl & ~avs_writedata[`TIC_BIT_T0OVF];
  assign e1SwClr = wrCtrl & ~avs_writedata[`TIC_BIT_E1FLAG];
  assign e0SwClr = wrCtrl & ~avs_writedata[`TIC_BIT_E0FLAG];

  // Control byte layout
  assign ctrlByte = {t1Ovf_r, t1Run_r, t0Ovf_r, t0Run_r,
                     e1Flag, e1Type_r, e0Flag, e0Type_r};

  // Read selection; unmapped addresses read zero
  assign readMux = hitCtrl ? {24'h000000, ctrlByte} :
                   hitStat ? {28'h0000000, irqStat_r} :
                   hitMask ? {28'h0000000, irqMask_r} :
                   hitPol ? {30'h00000000, polarity_r} : 32'h00000000;

  // Interrupt events: t1 ovf, t0 ovf, e1 flag set, e0 flag set
  assign evtVec = {t1Overflow, t0Overflow,
                   e1Edge | (~e1Type_r & e1Flag), e0Edge | (~e0Type_r & e0Flag)};
  // New events win over the read clear
  assign irqStat_nxt = evtVec | (rdStat ? 4'h0 : irqStat_r);

  // Outputs to the timers and the core
  assign t1RunEn = t1Run_r;
  assign t0RunEn = t0Run_r;
  assign ext1IrqReq = e1Flag;
  assign ext0IrqReq = e0Flag;
  assign irq = |(irqStat_r & irqMask_r);
  assign avs_readdata = readData_r;

  // Bus handshake state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busState_r <= TIC_IDLE;
      readData_r <= 32'h00000000;
    end else begin
      case (busState_r)
        TIC_IDLE: begin
          if (access) begin
            busState_r <= TIC_RESP;
            readData_r <= avs_read ? readMux : 32'h00000000;
          end
        end
        TIC_RESP: busState_r <= TIC_IDLE;
        default: busState_r <= TIC_IDLE;
      endcase
    end
  end

  // Timer overflow flags: hardware set beats any clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t1Ovf_r <= 1'b0;
      t0Ovf_r <= 1'b0;
    end else begin
      t1Ovf_r <= t1Overflow | (t1Ovf_r & ~t1SwClr & ~t1Vector);
      t0Ovf_r <= t0Overflow | (t0Ovf_r & ~t0SwClr & ~t0Vector);
    end
  end

  // Software-written control bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t1Run_r <= 1'b0;
      t0Run_r <= 1'b0;
      e1Type_r <= 1'b0;
      e0Type_r <= 1'b0;
      polarity_r <= `TIC_POL_RST;
      irqMask_r <= 4'h0;
    end else begin
      if (wrCtrl) begin
        t1Run_r <= avs_writedata[`TIC_BIT_T1RUN];
        t0Run_r <= avs_writedata[`TIC_BIT_T0RUN];
        e1Type_r <= avs_writedata[`TIC_BIT_E1TYPE];
        e0Type_r <= avs_writedata[`TIC_BIT_E0TYPE];
      end
      if (wrLow & hitPol) begin
        polarity_r <= avs_writedata[1:0];
      end
      if (wrLow & hitMask) begin
        irqMask_r <= avs_writedata[3:0];
      end
    end
  end

  // Sticky interrupt status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= 4'h0;
    end else begin
      irqStat_r <= irqStat_nxt;
    end
  end

  // Checks
  t1_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    t1Overflow |=> t1Ovf_r) else $error("t1 flag not set");
  t1_vec_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    t1Vector && !t1Overflow |=> !t1Ovf_r) else $error("t1 flag not cleared");
  t1_run_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrCtrl |=> t1RunEn == $past(avs_writedata[6])) else $error("t1 run wrong");
  t0_flag_life_a: assert property (@(posedge clock) disable iff (!rst_n)
    t0Overflow ##1 !t0SwClr && !t0Vector && !t0Overflow |=> t0Ovf_r)
    else $error("t0 flag lost");
  t0_run_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrCtrl |=> t0RunEn == $past(avs_writedata[4])) else $error("t0 run wrong");
  e1_edge_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    e1Edge |=> e1Flag || !e1Type_r) else $error("e1 edge lost");
  e1_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    !e1Type_r |-> e1Flag == (polarity_r[1] ? in1Sync : !in1Sync))
    else $error("e1 level wrong");
  e0_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    !e0Type_r |-> e0Flag == (polarity_r[0] ? in0Sync : !in0Sync))
    else $error("e0 level wrong");
  // Read data was captured one edge before the accept edge
  ctrl_layout_a: assert property (@(posedge clock) disable iff (!rst_n)
    taken && avs_read && hitCtrl |->
    avs_readdata[7] == $past(t1Ovf_r) && avs_readdata[5] == $past(t0Ovf_r))
    else $error("ctrl layout wrong");
  irq_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq == |(irqStat_r & irqMask_r)) else $error("irq mismatch");
  bus_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
    access && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  cov_t1_ovf_c: cover property (@(posedge clock) disable iff (!rst_n) t1Overflow ##1 t1Vector);
  cov_e0_edge_c: cover property (@(posedge clock) disable iff (!rst_n) e0Edge);
  cov_irq_c: cover property (@(posedge clock) disable iff (!rst_n) irq ##1 rdStat);
endmodule
`default_nettype wire

// ### tb/tic_core_model.sv
// Behavioural timers, core vectoring and external pins facing the bank
`timescale 1ns/1ps
`default_nettype none
module tic_core_model (
  input wire logic clock,
  output logic t1Overflow,
  output logic t0Overflow,
  output logic t1Vector,
  output logic t0Vector,
  output logic ext1Vector,
  output logic ext0Vector,
  output logic pinOne,
  output logic pinZero
);
  logic [5:0] evt = 6'h00;
  // Bit 5 down: t1 ovf, t0 ovf, t1 vec, t0 vec, e1 vec, e0 vec
  assign {t1Overflow, t0Overflow, t1Vector, t0Vector, ext1Vector, ext0Vector} = evt;
  // Pins idle high, inactive for the reset polarity
  initial begin
    pinOne = 1'b1;
    pinZero = 1'b1;
  end
  // One-cycle event, as a timer or the core would give it
  task automatic pulse(input int idx);
    @(posedge clock);
    evt <= 6'h01 << idx;
    @(posedge clock);
    evt <= 6'h00;
  endtask
  // Pin change, then time for the two-flop synchroniser
  task automatic pins(input logic one, input logic zero);
    @(posedge clock);
    pinOne <= one;
    pinZero <= zero;
    repeat (5) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### tb/timer_ext_irq_control_reg_bench.sv
// Self-checking bench for the timer/interrupt control bank
`timescale 1ns/1ps
`default_nettype none
`include "tic_consts.svh"
module timer_ext_irq_control_reg_bench;
  import tic_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  tic_word_t wdata = 32'h0;
  tic_word_t rdata;
  logic waitReq, t1RunEn, t0RunEn, ext1IrqReq, ext0IrqReq, irq;
  wire logic t1Ovf, t0Ovf, t1Vec, t0Vec, e1Vec, e0Vec, pinOne, pinZero;
  logic [63:0] expQ [$];
  logic [63:0] note;
  int fails = 0;
  int checks = 0;
  tic_byte_t ctrl;
  always #25 clock = ~clock;
  tic_control DUT (.clock(clock), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .t1Overflow(t1Ovf), .t0Overflow(t0Ovf), .t1Vector(t1Vec),
    .t0Vector(t0Vec), .ext1Vector(e1Vec), .ext0Vector(e0Vec), .ext_irq_in_one(pinOne),
    .ext_irq_in_zero(pinZero), .t1RunEn(t1RunEn), .t0RunEn(t0RunEn),
    .ext1IrqReq(ext1IrqReq), .ext0IrqReq(ext0IrqReq), .irq(irq));
  tic_core_model core (.clock(clock), .t1Overflow(t1Ovf), .t0Overflow(t0Ovf),
    .t1Vector(t1Vec), .t0Vector(t0Vec), .ext1Vector(e1Vec), .ext0Vector(e0Vec),
    .pinOne(pinOne), .pinZero(pinZero));
  task automatic check(input string what, input tic_word_t seen, input tic_word_t exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    // Reads still waiting for their answer count as mismatches
    fails += expQ.size();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One Avalon cycle; reads note d under mask m, writes use m[3:0] as byteenable
  task automatic bus(input logic isRd, input logic [7:0] a, input tic_word_t d,
    input tic_word_t m);
    @(posedge clock);
    addr <= a;
    rd <= isRd;
    wr <= !isRd;
    wdata <= d;
    be <= isRd ? 4'hF : m[3:0];
    if (isRd)
      expQ.push_back({m, d});
    // Hold until waitrequest is seen low; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (waitReq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Oldest noted read is compared at the accept edge
  always @(posedge clock) begin
    if (rd && waitReq === 1'b0 && expQ.size() > 0) begin
      note = expQ.pop_front();
      check("readdata", rdata & note[63:32], note[31:0]);
    end
  end
  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hFD7ECEFE));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    bus(1, `TIC_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    bus(1, `TIC_OFF_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
    bus(1, `TIC_OFF_POLARITY, 32'h0, 32'hFFFFFFFF);
    bus(1, 8'hFC, 32'h0, 32'hFFFFFFFF);
    // Every run combination, edge types; random 1s on flags must not set them
    for (int i = 0; i < 4; i++) begin
      ctrl = {1'b0, i[1], 1'b0, i[0], 4'h5};
      bus(0, `TIC_OFF_CTRL, ctrl | ($urandom & 8'hAA), 32'hF);
      bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
      check("t1RunEn", t1RunEn, ctrl[6]);
      check("t0RunEn", t0RunEn, ctrl[4]);
    end
    core.pulse(5);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h80, 32'hFFFFFFFF);
    bus(0, `TIC_OFF_CTRL, ctrl, 32'hF);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    core.pulse(5);
    core.pulse(3);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    core.pulse(4);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h20, 32'hFFFFFFFF);
    core.pulse(2);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    // Edge mode latches a pulse on both pins
    core.pins(1'b0, 1'b0);
    core.pins(1'b1, 1'b1);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h0A, 32'hFFFFFFFF);
    check("ext1IrqReq", ext1IrqReq, 1'b1);
    core.pulse(1);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h02, 32'hFFFFFFFF);
    bus(0, `TIC_OFF_CTRL, ctrl, 32'hF);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    // Vector clears input zero only; a written 1 never sets a flag
    core.pins(1'b0, 1'b0);
    core.pins(1'b1, 1'b1);
    core.pulse(0);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h08, 32'hFFFFFFFF);
    bus(0, `TIC_OFF_CTRL, ctrl | 8'h02, 32'hF);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    // Level mode follows the pins
    ctrl = 8'h50;
    bus(0, `TIC_OFF_CTRL, ctrl, 32'hF);
    core.pins(1'b0, 1'b1);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h08, 32'hFFFFFFFF);
    check("ext0IrqReq", ext0IrqReq, 1'b0);
    core.pins(1'b1, 1'b0);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h02, 32'hFFFFFFFF);
    core.pins(1'b1, 1'b1);
    bus(1, `TIC_OFF_CTRL, ctrl, 32'hFFFFFFFF);
    // Active-high polarity turns idle-high pins active
    bus(0, `TIC_OFF_POLARITY, 32'h3, 32'hF);
    repeat (5) @(posedge clock);
    bus(1, `TIC_OFF_CTRL, ctrl | 8'h0A, 32'hFFFFFFFF);
    bus(0, `TIC_OFF_POLARITY, 32'h0, 32'hF);
    repeat (5) @(posedge clock);
    // Sticky status, read-clear, mask and level interrupt
    bus(1, `TIC_OFF_IRQ_STAT, 32'hF, 32'hFFFFFFFF);
    bus(1, `TIC_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF);
    bus(0, `TIC_OFF_IRQ_MASK, 32'h8, 32'hF);
    bus(0, `TIC_OFF_IRQ_MASK, 32'h0, 32'h0);
    bus(1, `TIC_OFF_IRQ_MASK, 32'h8, 32'hFFFFFFFF);
    core.pulse(5);
    @(negedge clock);
    check("irq", irq, 1'b1);
    bus(1, `TIC_OFF_IRQ_STAT, 32'h8, 32'hFFFFFFFF);
    @(negedge clock);
    check("irq", irq, 1'b0);
    core.pulse(4);
    @(negedge clock);
    check("irq", irq, 1'b0);
    bus(1, `TIC_OFF_IRQ_STAT, 32'h4, 32'hFFFFFFFF);
    repeat (2) @(posedge clock);
    report_and_stop();
  end
endmodule
`default_nettype wire
